// file: include/cfm_pkg.sv
package cfm_pkg;

   // ************************************************************
   // Word and field geometry
   // ************************************************************
   localparam int WORD_W = 60;
   localparam int CHAR_W = 6;
   localparam int ADDR_W = 18;
   localparam int LEN_W = 7;
   localparam int CNT_W = 9;
   localparam logic [3:0] LAST_POS = 4'h9;
   localparam logic [7:0] CHARS_PER_WORD = 8'h0a;
   localparam int FIFO_DEPTH = 16;

   // ************************************************************
   // Opcodes (octal 465, 466, 467)
   // ************************************************************
   localparam logic [8:0] OP_MOVE = 9'h135;
   localparam logic [8:0] OP_CMP_TBL = 9'h136;
   localparam logic [8:0] OP_CMP_RAW = 9'h137;

   // ************************************************************
   // Reset values
   // ************************************************************
   localparam logic [WORD_W-1:0] RESULT_RST = 60'h0;

   // Field layout of the instruction word, bit 59 first
   typedef struct packed {
      logic [8:0] opcode;
      logic [2:0] length_upper_part;
      logic [ADDR_W-1:0] source_word_addr;
      logic [3:0] length_lower_part;
      logic [3:0] source_char_pos;
      logic [3:0] result_char_pos;
      logic [ADDR_W-1:0] result_word_addr;
   } cfm_instr_s;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [WORD_W-1:0] data;
   } cfm_wreq_s;

   typedef enum {
      ST_IDLE, ST_RD_A, ST_RD_B, ST_STEP, ST_TBL_A, ST_TBL_B, ST_PUSH, ST_DRAIN
   } cfm_state_e;

endpackage

// file: rtl/cfm_char_string_unit.sv
// ************************************************************
// Write-back queue
// ************************************************************
module cfm_fifo #(
   parameter int WIDTH = 78,
   parameter int DEPTH = 16
) (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int PW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [PW:0] wr_ptr_r;
   logic [PW:0] rd_ptr_r;
   wire full = (wr_ptr_r[PW] != rd_ptr_r[PW]) && (wr_ptr_r[PW-1:0] == rd_ptr_r[PW-1:0]);
   wire empty = (wr_ptr_r == rd_ptr_r);
   wire do_wr = in_valid_i && !full;
   wire do_rd = out_ready_i && !empty;

   assign in_ready_o = !full;
   assign out_valid_o = !empty;
   assign out_data_o = mem_r[rd_ptr_r[PW-1:0]];

   always_ff @(posedge clk_sys_i) begin
      if (do_wr) begin
         mem_r[wr_ptr_r[PW-1:0]] <= in_data_i;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
      end else begin
         wr_ptr_r <= wr_ptr_r + (PW+1)'(do_wr);
         rd_ptr_r <= rd_ptr_r + (PW+1)'(do_rd);
      end
   end
endmodule

// Functional notes
// - Move opcode copies source characters to result field, all from instruction word.
// - Decode source/result word addresses, char positions, low length from fixed bit fields.
// - Table compare scans left to right, collates differing pairs, resumes if equal.
// - Result: greater gives zeros plus count, equal zeros, less ones plus complement.
// - Count is pairs not yet compared plus one.
// - Table base addresses eight consecutive words; software preloads them.
// - Table word is base plus upper three bits; lower three pick character.
// - Raw compare uses codes directly, loads result at first difference or end.
// - Each word holds ten six-bit characters; fields start or end anywhere.
// - Position above nine or field beyond memory limit: instruction not executed.
// - Zero combined length makes a legal instruction a pass.
// - Instruction outside parcel zero is illegal.
module cfm_char_string_unit #(
   parameter int FIFO_DEPTH = cfm_pkg::FIFO_DEPTH
) (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic start_i,
   input wire logic parcel_zero_i,
   input wire logic [cfm_pkg::WORD_W-1:0] instr_word_i,
   input wire logic [cfm_pkg::ADDR_W-1:0] collate_table_base_i,
   input wire logic [cfm_pkg::ADDR_W-1:0] memory_field_limit_i,
   output logic busy_o,
   output logic done_o,
   output logic illegal_o,
   output logic range_err_o,
   output logic result_load_o,
   output logic [cfm_pkg::WORD_W-1:0] compare_result_reg_o,
   output logic rd_req_o,
   output logic [cfm_pkg::ADDR_W-1:0] rd_addr_o,
   input wire logic rd_ack_i,
   input wire logic [cfm_pkg::WORD_W-1:0] rd_data_i,
   output logic wr_valid_o,
   input wire logic wr_ready_i,
   output cfm_pkg::cfm_wreq_s wr_req_o
);
   // ************************************************************
   // Helpers
   // ************************************************************
   function automatic logic [5:0] char_at(logic [59:0] w, logic [3:0] p);
      logic [59:0] sh;
      sh = w >> (6 * (9 - int'(p)));
      return sh[5:0];
   endfunction

   function automatic logic [59:0] put_char(logic [59:0] w, logic [3:0] p, logic [5:0] c);
      int shamt;
      shamt = 6 * (9 - int'(p));
      return (w & ~(60'h3f << shamt)) | ({54'h0, c} << shamt);
   endfunction

   function automatic logic [59:0] result_of(logic gt, logic [8:0] cnt);
      return gt ? {51'h0, cnt} : {51'h7ffffffffffff, ~cnt};
   endfunction

   // ************************************************************
   // State
   // ************************************************************
   cfm_pkg::cfm_state_e state_r, state_nxt;
   logic is_move_r, is_move_nxt, is_tbl_r, is_tbl_nxt, need_b_r, need_b_nxt, need_a_r, need_a_nxt;
   logic [17:0] a_addr_r, a_addr_nxt, b_addr_r, b_addr_nxt;
   logic [3:0] a_pos_r, a_pos_nxt, b_pos_r, b_pos_nxt;
   logic [59:0] a_word_r, a_word_nxt, b_word_r, b_word_nxt, res_r, res_nxt;
   logic [6:0] remain_r, remain_nxt;
   logic [5:0] ta_r, ta_nxt;
   logic done_r, done_nxt, ill_r, ill_nxt, rng_r, rng_nxt, load_r, load_nxt;

   // ************************************************************
   // Decode and range check of the incoming instruction
   // ************************************************************
   cfm_pkg::cfm_instr_s in_s;
   assign in_s = cfm_pkg::cfm_instr_s'(instr_word_i);
   wire [6:0] in_len = {in_s.length_upper_part, in_s.length_lower_part};
   wire op_ok = (in_s.opcode == cfm_pkg::OP_MOVE) || (in_s.opcode == cfm_pkg::OP_CMP_TBL)
      || (in_s.opcode == cfm_pkg::OP_CMP_RAW);
   wire [7:0] a_last = 8'(in_s.source_char_pos) + 8'(in_len) - 8'h01;
   wire [7:0] b_last = 8'(in_s.result_char_pos) + 8'(in_len) - 8'h01;
   wire [7:0] a_words = 8'(a_last / cfm_pkg::CHARS_PER_WORD) + 8'h01;
   wire [7:0] b_words = 8'(b_last / cfm_pkg::CHARS_PER_WORD) + 8'h01;
   wire pos_bad = (in_s.source_char_pos > cfm_pkg::LAST_POS)
      || (in_s.result_char_pos > cfm_pkg::LAST_POS);
   wire lim_bad = ({1'b0, in_s.source_word_addr} + 19'(a_words) > {1'b0, memory_field_limit_i})
      || ({1'b0, in_s.result_word_addr} + 19'(b_words) > {1'b0, memory_field_limit_i});
   wire take = start_i && (state_r == cfm_pkg::ST_IDLE);
   wire go_illegal = take && (!parcel_zero_i || !op_ok);
   wire go_pass = take && !go_illegal && (in_len == 7'h00);
   wire go_range = take && !go_illegal && !go_pass && (pos_bad || lim_bad);
   wire go_run = take && !go_illegal && !go_pass && !go_range;

   // ************************************************************
   // Character taps and memory request
   // ************************************************************

   wire [5:0] ca = char_at(a_word_r, a_pos_r);
   wire [5:0] cb = char_at(b_word_r, b_pos_r);
   wire [5:0] tb = char_at(rd_data_i, {1'b0, cb[2:0]});
   wire a_wrap = (a_pos_r == cfm_pkg::LAST_POS);
   wire b_wrap = (b_pos_r == cfm_pkg::LAST_POS);
   wire last = (remain_r == 7'h01);
   wire [8:0] count = 9'(remain_r);
   wire [17:0] tbl_addr = collate_table_base_i + 18'(state_r == cfm_pkg::ST_TBL_A ? ca[5:3]
      : cb[5:3]);
   wire fifo_ready;
   wire fifo_out_valid;
   cfm_pkg::cfm_wreq_s push_req;
   assign push_req = '{addr: b_addr_r, data: b_word_r};

   assign rd_req_o = (state_r == cfm_pkg::ST_RD_A) || (state_r == cfm_pkg::ST_RD_B)
      || (state_r == cfm_pkg::ST_TBL_A) || (state_r == cfm_pkg::ST_TBL_B);
   assign rd_addr_o = (state_r == cfm_pkg::ST_RD_A) ? a_addr_r
      : (state_r == cfm_pkg::ST_RD_B) ? b_addr_r : tbl_addr;
   assign busy_o = (state_r != cfm_pkg::ST_IDLE);
   assign done_o = done_r;
   assign illegal_o = ill_r;
   assign range_err_o = rng_r;
   assign result_load_o = load_r;
   assign compare_result_reg_o = res_r;

   // ************************************************************
   // Sequencer
   // ************************************************************
   always_comb begin
      logic adv;
      logic fin_eq;
      adv = 1'b0;
      fin_eq = 1'b0;
      state_nxt = state_r;
      is_move_nxt = is_move_r;
      is_tbl_nxt = is_tbl_r;
      need_a_nxt = need_a_r;
      need_b_nxt = need_b_r;
      a_addr_nxt = a_addr_r;
      b_addr_nxt = b_addr_r;
      a_pos_nxt = a_pos_r;
      b_pos_nxt = b_pos_r;
      a_word_nxt = a_word_r;
      b_word_nxt = b_word_r;
      remain_nxt = remain_r;
      res_nxt = res_r;
      ta_nxt = ta_r;
      done_nxt = go_pass;
      ill_nxt = go_illegal;
      rng_nxt = go_range;
      load_nxt = 1'b0;
      unique case (state_r)
         cfm_pkg::ST_IDLE: begin
            if (go_run) begin
               is_move_nxt = (in_s.opcode == cfm_pkg::OP_MOVE);
               is_tbl_nxt = (in_s.opcode == cfm_pkg::OP_CMP_TBL);
               a_addr_nxt = in_s.source_word_addr;
               b_addr_nxt = in_s.result_word_addr;
               a_pos_nxt = in_s.source_char_pos;
               b_pos_nxt = in_s.result_char_pos;
               remain_nxt = in_len;
               need_b_nxt = 1'b1;
               state_nxt = cfm_pkg::ST_RD_A;
            end
         end
         cfm_pkg::ST_RD_A: begin
            if (rd_ack_i) begin
               a_word_nxt = rd_data_i;
               state_nxt = need_b_r ? cfm_pkg::ST_RD_B : cfm_pkg::ST_STEP;
            end
         end
         cfm_pkg::ST_RD_B: begin
            if (rd_ack_i) begin
               b_word_nxt = rd_data_i;
               need_b_nxt = 1'b0;
               state_nxt = cfm_pkg::ST_STEP;
            end
         end
         cfm_pkg::ST_STEP: begin
            if (is_move_r) begin
               b_word_nxt = put_char(b_word_r, b_pos_r, ca);
               adv = 1'b1;
            end else if (ca == cb) begin
               adv = 1'b1;
               fin_eq = last;
            end else if (is_tbl_r) begin
               state_nxt = cfm_pkg::ST_TBL_A;
            end else begin
               res_nxt = result_of(ca > cb, count);
               load_nxt = 1'b1;
               done_nxt = 1'b1;
               state_nxt = cfm_pkg::ST_IDLE;
            end
         end
         cfm_pkg::ST_TBL_A: begin
            if (rd_ack_i) begin
               ta_nxt = char_at(rd_data_i, {1'b0, ca[2:0]});
               state_nxt = cfm_pkg::ST_TBL_B;
            end
         end
         cfm_pkg::ST_TBL_B: begin
            if (rd_ack_i && ta_r == tb) begin
               adv = 1'b1;
               fin_eq = last;
            end else if (rd_ack_i) begin
               res_nxt = result_of(ta_r > tb, count);
               load_nxt = 1'b1;
               done_nxt = 1'b1;
               state_nxt = cfm_pkg::ST_IDLE;
            end
         end
         cfm_pkg::ST_PUSH: begin
            if (fifo_ready) begin
               b_addr_nxt = b_addr_r + 18'h1;
               need_b_nxt = (remain_r != 7'h00);
               state_nxt = (remain_r == 7'h00) ? cfm_pkg::ST_DRAIN
                  : need_a_r ? cfm_pkg::ST_RD_A : cfm_pkg::ST_RD_B;
            end
         end
         cfm_pkg::ST_DRAIN: begin
            // Done only once every result word has left the queue
            if (!fifo_out_valid) begin
               done_nxt = 1'b1;
               state_nxt = cfm_pkg::ST_IDLE;
            end
         end
      endcase
      if (adv) begin
         remain_nxt = remain_r - 7'h01;
         a_pos_nxt = a_wrap ? 4'h0 : a_pos_r + 4'h1;
         b_pos_nxt = b_wrap ? 4'h0 : b_pos_r + 4'h1;
         need_a_nxt = a_wrap && !last;
         if (a_wrap) begin
            a_addr_nxt = a_addr_r + 18'h1;
         end
         if (is_move_r) begin
            state_nxt = (b_wrap || last) ? cfm_pkg::ST_PUSH
               : a_wrap ? cfm_pkg::ST_RD_A : cfm_pkg::ST_STEP;
         end else if (fin_eq) begin
            res_nxt = cfm_pkg::RESULT_RST;
            load_nxt = 1'b1;
            done_nxt = 1'b1;
            state_nxt = cfm_pkg::ST_IDLE;
         end else begin
            need_b_nxt = b_wrap;
            if (b_wrap) begin
               b_addr_nxt = b_addr_r + 18'h1;
            end
            state_nxt = a_wrap ? cfm_pkg::ST_RD_A : b_wrap ? cfm_pkg::ST_RD_B : cfm_pkg::ST_STEP;
         end
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         state_r <= cfm_pkg::ST_IDLE;
         {is_move_r, is_tbl_r, need_a_r, need_b_r} <= 4'h0;
         {done_r, ill_r, rng_r, load_r} <= 4'h0;
         res_r <= cfm_pkg::RESULT_RST;
      end else begin
         state_r <= state_nxt;
         {is_move_r, is_tbl_r, need_a_r, need_b_r} <= {is_move_nxt, is_tbl_nxt, need_a_nxt,
            need_b_nxt};
         {done_r, ill_r, rng_r, load_r} <= {done_nxt, ill_nxt, rng_nxt, load_nxt};
         res_r <= res_nxt;
      end
   end

   // Datapath registers need no reset; they are loaded before use
   always_ff @(posedge clk_sys_i) begin
      {a_addr_r, b_addr_r, a_pos_r, b_pos_r} <= {a_addr_nxt, b_addr_nxt, a_pos_nxt, b_pos_nxt};
      {a_word_r, b_word_r, remain_r, ta_r} <= {a_word_nxt, b_word_nxt, remain_nxt, ta_nxt};
   end

   // ************************************************************
   // Write-back queue: a slow memory write port stalls a push only when the queue is full, and holds done in ST_DRAIN until the queue is empty
   // ************************************************************
   cfm_fifo #(
      .WIDTH($bits(cfm_pkg::cfm_wreq_s)),
      .DEPTH(FIFO_DEPTH)
   ) u_wq (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .in_valid_i(state_r == cfm_pkg::ST_PUSH),
      .in_ready_o(fifo_ready),
      .in_data_i(push_req),
      .out_valid_o(fifo_out_valid),
      .out_ready_i(wr_ready_i),
      .out_data_o(wr_req_o)
   );
   assign wr_valid_o = fifo_out_valid;

   // ************************************************************
   // Checks
   // ************************************************************
   default clocking @(posedge clk_sys_i);
   endclocking
   default disable iff (rst_i);

   sequence s_start_pass;
      go_pass ##1 done_o;
   endsequence

   illegal_parcel_a: assert property (take && !parcel_zero_i |=> illegal_o && !busy_o)
      else $error("string op outside parcel zero not refused");
   pass_zero_len_a: assert property (go_pass |-> s_start_pass ##0 !busy_o)
      else $error("zero length did not pass");
   range_refuse_a: assert property (take && parcel_zero_i && op_ok && in_len != 7'h00 && pos_bad
      |=> range_err_o && !busy_o && !rd_req_o)
      else $error("out of range position executed");
   decode_fields_a: assert property (go_run |=> a_addr_r == $past(in_s.source_word_addr)
      && b_pos_r == $past(in_s.result_char_pos) && remain_r == $past(in_len))
      else $error("instruction fields misdecoded");
   table_addr_a: assert property (state_r == cfm_pkg::ST_TBL_A |-> rd_addr_o
      == collate_table_base_i + 18'(ca[5:3]))
      else $error("collate table word address wrong");
   raw_no_table_a: assert property (busy_o && !is_tbl_r |-> state_r != cfm_pkg::ST_TBL_A
      && state_r != cfm_pkg::ST_TBL_B)
      else $error("raw compare used the table");
   result_shape_a: assert property (load_nxt |=> result_load_o && ((res_r[59:9] == 51'h0
      && res_r[8:0] == $past(count)) || (res_r[59:9] == 51'h7ffffffffffff
      && res_r[8:0] == ~$past(count)) || (res_r == 60'h0 && $past(remain_r) == 7'h01)))
      else $error("compare result format wrong");
   pos_wrap_a: assert property (state_r == cfm_pkg::ST_STEP && is_move_r && a_wrap && !last
      |=> a_pos_r == 4'h0 && a_addr_r == $past(a_addr_r) + 18'h1)
      else $error("position did not wrap to next word");
   move_char_a: assert property (state_r == cfm_pkg::ST_STEP && is_move_r
      |=> char_at(b_word_r, $past(b_pos_r)) == $past(ca))
      else $error("moved character wrong");
endmodule

// file: test/cfm_mem_model.sv
// ************************************************************
// Central memory: random read latency, random write stalls
// ************************************************************
module cfm_mem_model (
   input wire logic clk_sys_i,
   input wire logic rd_req_i,
   input wire logic [cfm_pkg::ADDR_W-1:0] rd_addr_i,
   output logic rd_ack_o,
   output logic [cfm_pkg::WORD_W-1:0] rd_data_o,
   input wire logic wr_valid_i,
   input wire logic wr_hold_i,
   output logic wr_ready_o,
   input wire cfm_pkg::cfm_wreq_s wr_req_i
);
   timeunit 1ns;
   timeprecision 100ps;
   // Table words are preloaded here by the bench before a compare
   logic [cfm_pkg::WORD_W-1:0] mem [0:255];
   logic [1:0] lat_r = 2'h0;
   logic wr_rdy_r = 1'b0;
   int seed = 32'h14b6cc0a;
   assign wr_ready_o = wr_rdy_r;
   assign rd_ack_o = rd_req_i && (lat_r == 2'h0);
   // Unacked data shows the inverse so a stale sample cannot pass
   assign rd_data_o = rd_ack_o ? mem[rd_addr_i[7:0]] : ~mem[rd_addr_i[7:0]];
   always @(posedge clk_sys_i) begin
      if (rd_ack_o) begin
         lat_r <= 2'($random(seed));
      end else if (rd_req_i && lat_r != 2'h0) begin
         lat_r <= lat_r - 2'h1;
      end
      // Held port lets result words pile up in the queue
      wr_rdy_r <= !wr_hold_i && (2'($random(seed)) != 2'h0);
      if (wr_valid_i && wr_rdy_r) begin
         mem[wr_req_i.addr[7:0]] <= wr_req_i.data;
      end
   end
endmodule

// file: test/tb.sv
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   typedef struct packed {
      logic [2:0] kind;
      logic cmp;
      logic [59:0] val;
   } cfm_note_s;
   logic clk_sys_i, rst_i, start_i, parcel_zero_i;
   logic [59:0] instr_word_i;
   logic busy_o, done_o, illegal_o, range_err_o, result_load_o;
   logic [59:0] compare_result_reg_o, rd_data;
   logic rd_req, rd_ack, wr_valid, wr_ready;
   logic [17:0] rd_addr;
   cfm_pkg::cfm_wreq_s wr_req;
   logic wr_hold;
   logic [59:0] exp_w [0:13];
   cfm_note_s notes [$];
   cfm_note_s note;
   int num_errors = 0;
   int checks_done = 0;
   int seed = 32'h14b6cc0a;
   int i;

   initial begin
      clk_sys_i = 1'b0;
      forever #2 clk_sys_i = ~clk_sys_i;
   end

   cfm_char_string_unit #(.FIFO_DEPTH(16)) u_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
      .start_i(start_i), .parcel_zero_i(parcel_zero_i), .instr_word_i(instr_word_i),
      .collate_table_base_i(18'h00064), .memory_field_limit_i(18'h000c8), .busy_o(busy_o),
      .done_o(done_o), .illegal_o(illegal_o), .range_err_o(range_err_o),
      .result_load_o(result_load_o), .compare_result_reg_o(compare_result_reg_o),
      .rd_req_o(rd_req), .rd_addr_o(rd_addr), .rd_ack_i(rd_ack), .rd_data_i(rd_data),
      .wr_valid_o(wr_valid), .wr_ready_i(wr_ready), .wr_req_o(wr_req));
   cfm_mem_model u_mem (.clk_sys_i(clk_sys_i), .rd_req_i(rd_req), .rd_addr_i(rd_addr),
      .rd_ack_o(rd_ack), .rd_data_o(rd_data), .wr_valid_i(wr_valid), .wr_hold_i(wr_hold),
      .wr_ready_o(wr_ready), .wr_req_i(wr_req));

   // ************************************************************
   // Helpers
   // ************************************************************
   task automatic check(input logic ok, input string m);
      checks_done++;
      if (ok !== 1'b1) begin
         $display("[FAIL] %0t %s", $time, m);
         num_errors++;
      end
   endtask
   task automatic close_out();
      if (num_errors == 0 && checks_done > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   function automatic logic [59:0] mk(logic [8:0] op, logic [6:0] len, logic [17:0] k1,
      logic [3:0] c1, logic [3:0] c2, logic [17:0] k2);
      return {op, len[6:4], k1, len[3:0], c1, c2, k2};
   endfunction
   function automatic logic [59:0] res(logic gt, logic [8:0] n);
      return gt ? {51'h0, n} : {{51{1'b1}}, ~n};
   endfunction
   task automatic put(input int w, input int p, input logic [5:0] c);
      u_mem.mem[w + p / 10][(9 - p % 10) * 6 +: 6] = c;
   endtask
   function automatic logic [5:0] get(int w, int p);
      return u_mem.mem[w + p / 10][(9 - p % 10) * 6 +: 6];
   endfunction
   // One instruction; the watcher below retires its note
   task automatic issue(input logic [59:0] w, input logic pz, input logic [2:0] kind,
      input logic cmp, input logic [59:0] val);
      int n;
      notes.push_back('{kind, cmp, val});
      @(posedge clk_sys_i);
      start_i <= 1'b1;
      instr_word_i <= w;
      parcel_zero_i <= pz;
      @(posedge clk_sys_i);
      start_i <= 1'b0;
      n = 0;
      while (notes.size() != 0 && n < 3000) begin
         @(posedge clk_sys_i);
         n++;
      end
      if (n >= 3000) begin
         check(1'b0, "instruction never finished");
         close_out();
      end
   endtask

   // ************************************************************
   // Outcome watcher
   // ************************************************************
   always @(posedge clk_sys_i) begin
      #1;
      if (done_o === 1'b1 || illegal_o === 1'b1 || range_err_o === 1'b1) begin
         if (notes.size() == 0) begin
            check(1'b0, "unexpected completion");
         end else begin
            note = notes.pop_front();
            check({illegal_o, range_err_o, done_o} === note.kind, "wrong outcome");
            check(result_load_o === note.cmp, "wrong result load");
            if (note.cmp)
               check(compare_result_reg_o === note.val, "wrong compare result");
         end
      end
   end

   // ************************************************************
   // Main sequence
   // ************************************************************
   initial begin
      rst_i = 1'b1;
      start_i = 1'b0;
      parcel_zero_i = 1'b0;
      instr_word_i = 60'h0;
      wr_hold = 1'b0;
      for (i = 0; i < 256; i++)
         u_mem.mem[i] = {28'($random(seed)), 32'($random(seed))};
      for (i = 0; i < 64; i++)
         put(100, (i / 8) * 10 + i % 8, 6'(i));
      repeat (6) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      @(posedge clk_sys_i);
      check(busy_o === 1'b0 && compare_result_reg_o === cfm_pkg::RESULT_RST, "reset");
      // Equal fields, then a greater pair at index 5
      for (i = 0; i < 20; i++) begin
         put(40, 2 + i, 6'($random(seed)));
         put(50, 9 + i, get(40, 2 + i));
      end
      issue(mk(cfm_pkg::OP_CMP_RAW, 20, 40, 2, 9, 50), 1, 3'b001, 1, 0);
      put(40, 7, 6'o30);
      put(50, 14, 6'o20);
      issue(mk(cfm_pkg::OP_CMP_RAW, 20, 40, 2, 9, 50), 1, 3'b001, 1, res(1, 15));
      put(50, 14, 6'o30);
      put(40, 5, 6'o11);
      put(50, 12, 6'o12);
      put(40, 9, 6'o05);
      put(50, 16, 6'o40);
      put(100, 12, 6'o11);
      issue(mk(cfm_pkg::OP_CMP_RAW, 20, 40, 2, 9, 50), 1, 3'b001, 1, res(0, 17));
      issue(mk(cfm_pkg::OP_CMP_TBL, 20, 40, 2, 9, 50), 1, 3'b001, 1, res(0, 13));
      put(100, 5, 6'o77);
      issue(mk(cfm_pkg::OP_CMP_TBL, 20, 40, 2, 9, 50), 1, 3'b001, 1, res(1, 13));
      // Move 27 characters across word boundaries
      for (i = 0; i < 27; i++)
         put(8, 7 + i, 6'($random(seed)));
      for (i = 0; i < 3; i++)
         exp_w[i] = u_mem.mem[20 + i];
      for (i = 0; i < 27; i++)
         exp_w[(3 + i) / 10][(9 - (3 + i) % 10) * 6 +: 6] = get(8, 7 + i);
      issue(mk(cfm_pkg::OP_MOVE, 27, 8, 7, 3, 20), 1, 3'b001, 0, 0);
      for (i = 0; i < 3; i++)
         check(u_mem.mem[20 + i] === exp_w[i], "moved field");
      check(compare_result_reg_o === res(1, 13), "move touched result");
      // Refusals and passes
      issue(mk(cfm_pkg::OP_CMP_RAW, 5, 40, 4'ha, 0, 50), 1, 3'b010, 0, 0);
      issue(mk(cfm_pkg::OP_MOVE, 13, 0, 0, 9, 198), 1, 3'b010, 0, 0);
      issue(mk(cfm_pkg::OP_MOVE, 1, 0, 0, 9, 199), 1, 3'b001, 0, 0);
      check(get(199, 9) === get(0, 0), "boundary move");
      issue(mk(cfm_pkg::OP_CMP_RAW, 5, 40, 2, 9, 50), 0, 3'b100, 0, 0);
      issue(mk(9'h134, 5, 40, 2, 9, 50), 1, 3'b100, 0, 0);
      issue(mk(cfm_pkg::OP_MOVE, 0, 40, 2, 9, 50), 0, 3'b100, 0, 0);
      for (i = 0; i < 3; i++)
         issue(mk(cfm_pkg::OP_MOVE + 9'(i), 0, 40, 4'hf, 9, 50), 1, 3'b001, 0, 0);
      // Longest move with the write port held: done waits for the queue
      for (i = 0; i < 127; i++)
         put(120, i, 6'($random(seed)));
      for (i = 0; i < 14; i++)
         exp_w[i] = u_mem.mem[140 + i];
      for (i = 0; i < 127; i++)
         exp_w[(5 + i) / 10][(9 - (5 + i) % 10) * 6 +: 6] = get(120, i);
      wr_hold <= 1'b1;
      fork
         begin
            repeat (600) @(posedge clk_sys_i);
            check(busy_o === 1'b1 && wr_valid === 1'b1 && notes.size() == 1, "queue hold");
            wr_hold <= 1'b0;
         end
      join_none
      issue(mk(cfm_pkg::OP_MOVE, 127, 120, 0, 5, 140), 1, 3'b001, 0, 0);
      for (i = 0; i < 14; i++)
         check(u_mem.mem[140 + i] === exp_w[i], "long move");
      check(wr_valid === 1'b0 && busy_o === 1'b0, "queue drain");
      close_out();
   end
endmodule
